/* logic/tsm_pkg.sv */
package tsm_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ        = 10_000_000;
  localparam int CONV_TIME_US  = 7800;
  localparam int CONV_CYC_DEF  = CONV_TIME_US * (CLK_HZ / 1_000_000);
  localparam int ONESHOT_MS    = 20;
  localparam int ONESHOT_CYC   = ONESHOT_MS * (CLK_HZ / 1000);
  localparam int WIND_TIME_MS  = 12;
  localparam int WIND_CYC_DEF  = WIND_TIME_MS * (CLK_HZ / 1000);
  localparam int RATE0_MILLIHZ = 250;
  localparam int RATE1_MILLIHZ = 1000;
  localparam int RATE2_MILLIHZ = 4000;
  localparam int RATE3_MILLIHZ = 8000;
  localparam int PER0_DEF      = (CLK_HZ / RATE0_MILLIHZ) * 1000;
  localparam int PER1_DEF      = (CLK_HZ / RATE1_MILLIHZ) * 1000;
  localparam int PER2_DEF      = (CLK_HZ / RATE2_MILLIHZ) * 1000;
  localparam int PER3_DEF      = (CLK_HZ / RATE3_MILLIHZ) * 1000;
  localparam int TMR_W         = 26;
  localparam int SCL_HZ        = 100_000;
  localparam int QTR_CYC_DEF   = CLK_HZ / (4 * SCL_HZ);

  // ************************************************************
  // device map and fields
  // ************************************************************
  localparam logic [6:0] DEV_ADDR_DEF = 7'h48;
  localparam logic [1:0] PTR_TEMP     = 2'h0;
  localparam logic [1:0] PTR_CONF     = 2'h1;
  localparam logic [7:0] CONF_RESET   = 8'h02;
  localparam int         MODE_LSB     = 0;
  localparam int         RATE_LSB     = 5;
  localparam logic [1:0] MODE_SHUT    = 2'h0;
  localparam logic [1:0] MODE_ONE     = 2'h1;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] ACK_DONE     = 4'h9;
  localparam logic [7:0] IDLE_BYTE    = 8'hff;
  localparam logic [7:0] RSVD_BYTE    = 8'h00;

  // ************************************************************
  // host register port
  // ************************************************************
  localparam logic [7:0] HREG_CMD   = 8'h00;
  localparam logic [7:0] HREG_WDATA = 8'h04;
  localparam logic [7:0] HREG_STAT  = 8'h08;
  localparam logic [7:0] HREG_RDATA = 8'h0c;
  localparam int         CMD_RD     = 0;
  localparam int         CMD_TWO    = 1;
  localparam int         CMD_PTR    = 2;
  localparam int         CMD_PSEL   = 4;

  typedef enum logic [1:0] {C_SHUT = 2'h0, C_CONV = 2'h1, C_STBY = 2'h3, C_WIND = 2'h2}
    tsm_conv_t;
  typedef enum logic [2:0] {S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h3, S_RX = 3'h2,
                            S_TX = 3'h6, S_MACK = 3'h7} tsm_slv_t;
  typedef enum logic [1:0] {H_IDLE = 2'h0, H_START = 2'h1, H_BYTE = 2'h3, H_STOP = 2'h2}
    tsm_host_t;
  typedef enum logic [2:0] {K_ADW = 3'h0, K_PTR = 3'h1, K_DAT = 3'h3, K_ADR = 3'h2,
                            K_RD0 = 3'h6, K_RD1 = 3'h7} tsm_kind_t;

endpackage

/* logic/tsm_bus_if.sv */
`timescale 1ns/100ps
interface tsm_bus_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // open-drain wires with pull-ups
  assign scl = !(!host_scl_oe_n && !host_scl_o);
  assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

  modport dev  (input scl, sda, output dev_sda_o, dev_sda_oe_n);
  modport host (input scl, sda, output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
endinterface

/* logic/tsm_device.sv */
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module tsm_device
  import tsm_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
  parameter int         CONV_CYC = CONV_CYC_DEF,
  parameter int         WIND_CYC = WIND_CYC_DEF,
  parameter int         PER0     = PER0_DEF,
  parameter int         PER1     = PER1_DEF,
  parameter int         PER2     = PER2_DEF,
  parameter int         PER3     = PER3_DEF
) (
  input  wire logic        sys_clk,     // system clock
  input  wire logic        reset,       // sync reset
  tsm_bus_if.dev           bus,         // serial link
  input  wire logic [11:0] temp_sample, // converter result
  output logic             busy,        // conversion running
  output logic [1:0]       mode         // mode field
);

  localparam int CONV_LEN = (CONV_CYC > ONESHOT_CYC) ? ONESHOT_CYC : CONV_CYC;

  // ************************************************************
  // link synchronisers and edges
  // ************************************************************
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= bus.scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= bus.sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign rise    = scl_s_q && !scl_p_q;
  assign fall    = !scl_s_q && scl_p_q;
  assign start_c = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_c  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

  // ************************************************************
  // conversion control state
  // ************************************************************
  tsm_conv_t          cst_q;
  tsm_conv_t          cst_d;
  logic [TMR_W-1:0]   tmr_q;
  logic [TMR_W-1:0]   tmr_d;
  logic [1:0]         mode_q;
  logic [1:0]         mode_d;
  logic [1:0]         rate_q;
  logic [1:0]         rate_d;
  logic [11:0]        temp_q;
  logic [11:0]        temp_d;
  logic               conf_wr;
  logic [7:0]         wbyte;
  logic [7:0]         conf_rd;

  function automatic logic [TMR_W-1:0] gap_of(input logic [1:0] r);
    int per;
    unique case (r)
      2'h0:    per = PER0;
      2'h1:    per = PER1;
      2'h2:    per = PER2;
      default: per = PER3;
    endcase
    return TMR_W'(per - CONV_LEN - 1);
  endfunction

  always_comb begin
    conf_rd = 8'h00;
    conf_rd[MODE_LSB +: 2] = mode_q;
    conf_rd[RATE_LSB +: 2] = rate_q;
  end

  always_comb begin
    cst_d  = cst_q;
    tmr_d  = tmr_q;
    mode_d = mode_q;
    rate_d = rate_q;
    temp_d = temp_q;
    if (tmr_q != '0) begin
      tmr_d = tmr_q - 1'b1;
    end
    unique case (cst_q)
      C_SHUT: begin
        if (mode_q == MODE_ONE || mode_q[1]) begin
          cst_d = C_CONV;
          tmr_d = TMR_W'(CONV_LEN - 1);
        end
      end
      C_CONV: begin
        if (tmr_q == '0) begin
          temp_d = temp_sample;
          if (mode_q == MODE_ONE) begin
            mode_d = MODE_SHUT;
            cst_d  = C_SHUT;
          end else if (mode_q[1]) begin
            cst_d = C_STBY;
            tmr_d = gap_of(rate_q);
          end else begin
            cst_d = C_WIND;
            tmr_d = TMR_W'(WIND_CYC - 1);
          end
        end
      end
      C_STBY: begin
        if (!mode_q[1] || (conf_wr && !wbyte[MODE_LSB + 1])) begin
          cst_d = C_WIND;
          tmr_d = TMR_W'(WIND_CYC - 1);
        end else if (tmr_q == '0) begin
          cst_d = C_CONV;
          tmr_d = TMR_W'(CONV_LEN - 1);
        end
      end
      C_WIND: begin
        if (tmr_q == '0) begin
          cst_d = C_SHUT;
        end
      end
    endcase
    if (conf_wr) begin
      rate_d = wbyte[RATE_LSB +: 2];
      if (wbyte[MODE_LSB +: 2] != MODE_ONE) begin
        mode_d = wbyte[MODE_LSB +: 2];
      end else if (cst_q == C_SHUT && mode_q == MODE_SHUT) begin
        mode_d = MODE_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cst_q  <= C_SHUT;
      tmr_q  <= '0;
      mode_q <= CONF_RESET[MODE_LSB +: 2];
      rate_q <= CONF_RESET[RATE_LSB +: 2];
      temp_q <= 12'h000;
    end else begin
      cst_q  <= cst_d;
      tmr_q  <= tmr_d;
      mode_q <= mode_d;
      rate_q <= rate_d;
      temp_q <= temp_d;
    end
  end

  assign busy = (cst_q == C_CONV);
  assign mode = mode_q;

  // ************************************************************
  // serial slave
  // ************************************************************
  tsm_slv_t    ist_q;
  tsm_slv_t    ist_d;
  logic [3:0]  bcnt_q;
  logic [3:0]  bcnt_d;
  logic [7:0]  shr_q;
  logic [7:0]  shr_d;
  logic        rw_q;
  logic        rw_d;
  logic        first_q;
  logic        first_d;
  logic [1:0]  ptr_q;
  logic [1:0]  ptr_d;
  logic        sdl_q;
  logic        sdl_d;
  logic        ack_q;
  logic        ack_d;
  logic        rsel_q;
  logic        rsel_d;
  logic [15:0] txs_q;
  logic [15:0] txs_d;
  logic [7:0]  out_byte;

  always_comb begin
    unique case (ptr_q)
      PTR_TEMP: out_byte = rsel_q ? txs_q[7:0] : txs_q[15:8];
      PTR_CONF: out_byte = conf_rd;
      default:  out_byte = RSVD_BYTE;
    endcase
  end

  assign wbyte = shr_q;

  always_comb begin
    ist_d   = ist_q;
    bcnt_d  = bcnt_q;
    shr_d   = shr_q;
    rw_d    = rw_q;
    first_d = first_q;
    ptr_d   = ptr_q;
    sdl_d   = sdl_q;
    ack_d   = ack_q;
    rsel_d  = rsel_q;
    txs_d   = txs_q;
    conf_wr = 1'b0;
    if (stop_c) begin
      ist_d = S_IDLE;
      sdl_d = 1'b0;
    end else if (start_c) begin
      ist_d  = S_ADDR;
      bcnt_d = 4'h0;
      sdl_d  = 1'b0;
    end else begin
      if (rise) begin
        bcnt_d = bcnt_q + 1'b1;
        if (ist_q == S_ADDR || ist_q == S_RX) begin
          shr_d = {shr_q[6:0], sda_s_q};
        end
      end
      unique case (ist_q)
        S_IDLE: ;
        S_ADDR: begin
          if (fall && bcnt_q == BYTE_BITS) begin
            if (shr_q[7:1] == DEV_ADDR) begin
              ist_d   = S_AACK;
              sdl_d   = 1'b1;
              rw_d    = shr_q[0];
              first_d = 1'b1;
              rsel_d  = 1'b0;
              txs_d   = {temp_q, 4'h0};
            end else begin
              ist_d = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (fall) begin
            bcnt_d = 4'h0;
            if (rw_q) begin
              ist_d = S_TX;
              shr_d = out_byte;
              sdl_d = !out_byte[7];
            end else begin
              ist_d = S_RX;
              sdl_d = 1'b0;
            end
          end
        end
        S_RX: begin
          if (fall && bcnt_q == BYTE_BITS) begin
            if (first_q) begin
              ptr_d = shr_q[1:0];
            end else if (ptr_q == PTR_CONF) begin
              conf_wr = 1'b1;
            end
            first_d = 1'b0;
            ist_d   = S_AACK;
            sdl_d   = 1'b1;
          end
        end
        S_TX: begin
          if (fall) begin
            if (bcnt_q == BYTE_BITS) begin
              ist_d = S_MACK;
              sdl_d = 1'b0;
            end else begin
              shr_d = {shr_q[6:0], 1'b0};
              sdl_d = !shr_q[6];
            end
          end
        end
        S_MACK: begin
          if (rise) begin
            ack_d = !sda_s_q;
            if (!sda_s_q) begin
              rsel_d = !rsel_q;
            end
          end else if (fall && bcnt_q == ACK_DONE) begin
            if (ack_q) begin
              ist_d  = S_TX;
              bcnt_d = 4'h0;
              shr_d  = out_byte;
              sdl_d  = !out_byte[7];
            end else begin
              ist_d = S_IDLE;
            end
          end
        end
        default: ist_d = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ist_q   <= S_IDLE;
      bcnt_q  <= 4'h0;
      shr_q   <= 8'h00;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      ptr_q   <= PTR_TEMP;
      sdl_q   <= 1'b0;
      ack_q   <= 1'b0;
      rsel_q  <= 1'b0;
      txs_q   <= 16'h0000;
    end else begin
      ist_q   <= ist_d;
      bcnt_q  <= bcnt_d;
      shr_q   <= shr_d;
      rw_q    <= rw_d;
      first_q <= first_d;
      ptr_q   <= ptr_d;
      sdl_q   <= sdl_d;
      ack_q   <= ack_d;
      rsel_q  <= rsel_d;
      txs_q   <= txs_d;
    end
  end

  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = !sdl_q;

endmodule

/* logic/tsm_host.sv */
`timescale 1ns/100ps
module tsm_host
  import tsm_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
  parameter int         QTR_CYC  = QTR_CYC_DEF
) (
  input  wire logic        sys_clk, // system clock
  input  wire logic        reset,   // sync reset
  tsm_bus_if.host          bus,     // serial link
  input  wire logic [7:0]  addr,    // register address
  input  wire logic [31:0] wdata,   // write data
  input  wire logic        wr,      // write strobe
  input  wire logic        rd,      // read strobe
  output logic      [31:0] rdata    // read data, next cycle
);

  // ************************************************************
  // link synchronisers
  // ************************************************************
  logic scl_m_q;
  logic scl_s_q;
  logic sda_m_q;
  logic sda_s_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= bus.scl;
      scl_s_q <= scl_m_q;
      sda_m_q <= bus.sda;
      sda_s_q <= sda_m_q;
    end
  end

  // ************************************************************
  // bit sequencer
  // ************************************************************
  tsm_host_t   hst_q, hst_d;
  tsm_kind_t   kind_q, kind_d;
  logic [15:0] qcnt_q, qcnt_d;
  logic [1:0]  ph_q, ph_d;
  logic [3:0]  bcnt_q, bcnt_d;
  logic [7:0]  tx_q, tx_d;
  logic [8:0]  rx_q, rx_d;
  logic        sclL_q, sclL_d;
  logic        sdaL_q, sdaL_d;
  logic        rdop_q, rdop_d;
  logic        two_q, two_d;
  logic [1:0]  psel_q, psel_d;
  logic [7:0]  wdat_q, wdat_d;
  logic [15:0] rdat_q, rdat_d;
  logic        nack_q, nack_d;
  logic [31:0] rdata_d;
  logic        tick;

  function automatic logic [7:0] byte_of(input tsm_kind_t k, input logic [1:0] p,
                                         input logic [7:0] d);
    unique case (k)
      K_ADW:   return {DEV_ADDR, 1'b0};
      K_ADR:   return {DEV_ADDR, 1'b1};
      K_PTR:   return {6'h00, p};
      K_DAT:   return d;
      default: return IDLE_BYTE;
    endcase
  endfunction

  assign tick = (qcnt_q == 16'(QTR_CYC - 1));

  always_comb begin
    hst_d  = hst_q;
    kind_d = kind_q;
    qcnt_d = (hst_q == H_IDLE || tick) ? 16'h0000 : qcnt_q + 1'b1;
    ph_d   = ph_q;
    bcnt_d = bcnt_q;
    tx_d   = tx_q;
    rx_d   = rx_q;
    sclL_d = sclL_q;
    sdaL_d = sdaL_q;
    rdop_d = rdop_q;
    two_d  = two_q;
    psel_d = psel_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    nack_d = nack_q;
    if (wr && addr == HREG_WDATA) begin
      wdat_d = wdata[7:0];
    end
    unique case (hst_q)
      H_IDLE: begin
        if (wr && addr == HREG_CMD) begin
          rdop_d = wdata[CMD_RD];
          two_d  = wdata[CMD_TWO];
          psel_d = wdata[CMD_PSEL +: 2];
          nack_d = 1'b0;
          kind_d = (wdata[CMD_RD] && !wdata[CMD_PTR]) ? K_ADR : K_ADW;
          hst_d  = H_START;
          ph_d   = 2'h0;
        end
      end
      H_START: begin
        if (tick && (ph_q != 2'h0 || sclL_q || (scl_s_q && sda_s_q))) begin
          ph_d = ph_q + 1'b1;
          unique case (ph_q)
            2'h0: sclL_d = 1'b0;
            2'h1: sdaL_d = 1'b1;
            2'h2: sclL_d = 1'b1;
            default: begin
              hst_d  = H_BYTE;
              bcnt_d = 4'h0;
              tx_d   = byte_of(kind_q, psel_q, wdat_q);
            end
          endcase
        end
      end
      H_BYTE: begin
        if (tick) begin
          ph_d = ph_q + 1'b1;
          unique case (ph_q)
            2'h0: begin
              if (bcnt_q < BYTE_BITS) begin
                sdaL_d = !tx_q[7];
                tx_d   = {tx_q[6:0], 1'b1};
              end else if (bcnt_q == BYTE_BITS) begin
                sdaL_d = (kind_q == K_RD0) && two_q;
              end else begin
                ph_d   = 2'h0;
                bcnt_d = 4'h0;
                sdaL_d = 1'b1;
                hst_d  = H_STOP;
                if (kind_q == K_RD0) begin
                  rdat_d[15:8] = rx_q[8:1];
                end else if (kind_q == K_RD1) begin
                  rdat_d[7:0] = rx_q[8:1];
                end else if (rx_q[0]) begin
                  nack_d = 1'b1;
                end
                unique case (kind_q)
                  K_ADW: if (!rx_q[0]) kind_d = K_PTR;
                  K_PTR: begin
                    if (!rx_q[0] && rdop_q) begin
                      kind_d = K_ADR;
                      sdaL_d = 1'b0;
                      hst_d  = H_START;
                    end else if (!rx_q[0] && two_q) begin
                      kind_d = K_DAT;
                    end
                  end
                  K_ADR: if (!rx_q[0]) kind_d = K_RD0;
                  K_RD0: if (two_q) kind_d = K_RD1;
                  default: ;
                endcase
                if (hst_d == H_STOP && kind_d != kind_q) begin
                  hst_d  = H_BYTE;
                  sdaL_d = sdaL_q;
                  tx_d   = byte_of(kind_d, psel_q, wdat_q);
                end
              end
            end
            2'h1: sclL_d = 1'b0;
            2'h2: ;
            default: begin
              rx_d   = {rx_q[7:0], sda_s_q};
              sclL_d = 1'b1;
              bcnt_d = bcnt_q + 1'b1;
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          ph_d = ph_q + 1'b1;
          unique case (ph_q)
            2'h0: sclL_d = 1'b0;
            2'h1: sdaL_d = 1'b0;
            2'h2: ;
            default: hst_d = H_IDLE;
          endcase
        end
      end
    endcase
    rdata_d = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        HREG_STAT:  rdata_d = {30'h0, nack_q, hst_q != H_IDLE};
        HREG_RDATA: rdata_d = {16'h0000, rdat_q};
        HREG_WDATA: rdata_d = {24'h00_0000, wdat_q};
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hst_q  <= H_IDLE;
      kind_q <= K_ADW;
      qcnt_q <= 16'h0000;
      ph_q   <= 2'h0;
      bcnt_q <= 4'h0;
      tx_q   <= IDLE_BYTE;
      rx_q   <= 9'h000;
      sclL_q <= 1'b0;
      sdaL_q <= 1'b0;
      rdop_q <= 1'b0;
      two_q  <= 1'b0;
      psel_q <= PTR_TEMP;
      wdat_q <= 8'h00;
      rdat_q <= 16'h0000;
      nack_q <= 1'b0;
      rdata  <= 32'h0000_0000;
    end else begin
      hst_q  <= hst_d;
      kind_q <= kind_d;
      qcnt_q <= qcnt_d;
      ph_q   <= ph_d;
      bcnt_q <= bcnt_d;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
      sclL_q <= sclL_d;
      sdaL_q <= sdaL_d;
      rdop_q <= rdop_d;
      two_q  <= two_d;
      psel_q <= psel_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      nack_q <= nack_d;
      rdata  <= rdata_d;
    end
  end

  assign bus.host_scl_o    = 1'b0;
  assign bus.host_scl_oe_n = !sclL_q;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = !sdaL_q;

endmodule

/* dv/tsm_monitor.sv */
`timescale 1ns/100ps
module tsm_monitor
  import tsm_pkg::*;
(
  input wire logic       sys_clk,      // clock
  input wire logic       reset,        // sync reset
  input wire logic       scl,          // link clock
  input wire logic       sda,          // link data
  input wire logic       dev_sda_oe_n, // device pull
  input wire logic       busy,         // converting
  input wire logic [1:0] mode          // mode field
);
  // ****************
  // helper counters
  // ****************
  logic [17:0] os_q, os_d;
  logic [3:0]  ck_q, ck_d;
  logic        scl_q, sda_q, cond;
  assign cond = scl && scl_q && (sda != sda_q);
  always_comb begin
    os_d = (mode == MODE_ONE) ? os_q + 18'h1 : 18'h0;
    ck_d = (scl && !scl_q) ? ((ck_q == ACK_DONE) ? 4'h1 : ck_q + 4'h1) : ck_q;
    if (cond) begin
      ck_d = 4'h0;
    end
  end
  always_ff @(posedge sys_clk) begin
    os_q  <= reset ? 18'h0 : os_d;
    ck_q  <= reset ? 4'h0 : ck_d;
    scl_q <= scl;
    sda_q <= sda;
  end
  // ****************
  // assertions
  // ****************
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (reset);
  one_time_a: assert property (os_q < ONESHOT_CYC)
    else $error("one-shot overran");
  one_hold_a: assert property ($past(mode) == MODE_ONE && busy |-> mode == MODE_ONE)
    else $error("mode left 01 while converting");
  one_end_a: assert property ($fell(busy) && $past(mode) == MODE_ONE |-> !mode)
    else $error("no return to shutdown");
  shut_idle_a: assert property (mode == MODE_SHUT |-> !$rose(busy))
    else $error("conversion in shutdown");
  rst_conf_a: assert property ($fell(reset) |-> mode == 2'h2 ##[1:2] busy)
    else $error("reset mode wrong");
  stby_gap_a: assert property (mode[1] && $fell(busy) |-> !busy [*8])
    else $error("no standby");
  dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data moved with clock high");
  byte_nine_a: assert property (cond |-> ck_q <= 4'h1)
    else $error("byte not nine clocks");
  cover property ($fell(busy) && mode == MODE_SHUT);
  cover property (cond && !sda);
  cover property (mode[1] && $rose(busy));
endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench
  import tsm_pkg::*;
;
  logic        sys_clk, reset, wr, rd, busy;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rv;
  logic [11:0] temp_sample;
  logic [1:0]  mode;
  int          mismatches, compares, rises, r0, seed;
  localparam int TB_CONV   = 50;
  localparam int TB_WIND   = 6000;
  localparam int TB_PER[4] = '{400, 300, 200, 120};
  time         t0;
  tsm_bus_if u_tsm_bus_if ();
  tsm_device #(.CONV_CYC(TB_CONV), .WIND_CYC(TB_WIND), .PER0(TB_PER[0]), .PER1(TB_PER[1]),
    .PER2(TB_PER[2]), .PER3(TB_PER[3])) u_tsm_device (.sys_clk, .reset, .bus(u_tsm_bus_if),
    .temp_sample,
    .busy, .mode);
  tsm_host u_tsm_host (.sys_clk, .reset, .bus(u_tsm_bus_if), .addr, .wdata, .wr,
    .rd, .rdata);
  tsm_monitor u_tsm_monitor (.sys_clk, .reset, .scl(u_tsm_bus_if.scl),
    .sda(u_tsm_bus_if.sda), .dev_sda_oe_n(u_tsm_bus_if.dev_sda_oe_n), .busy, .mode);
  // ****************
  // tasks
  // ****************
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge sys_clk);
    rv = rdata;
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] d);
    int n;
    n = 0;
    acc(1'b1, HREG_WDATA, {24'h0, d});
    acc(1'b1, HREG_CMD, {24'h0, cmd});
    rv = 32'h1;
    while (rv[0] !== 1'b0 && n < 9000) begin
      acc(1'b0, HREG_STAT, 32'h0);
      n++;
    end
    chk(rv, 32'h0);
    acc(1'b0, HREG_RDATA, 32'h0);
  endtask
  task automatic see(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, busy}, {31'h0, v});
  endtask
  // ****************
  // sequence
  // ****************
  always @(posedge busy) rises++;
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    mismatches++;
    finish_test;
  end
  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    seed = $urandom(32'h53af);
    temp_sample = 12'($urandom);
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    acc(1'b0, HREG_STAT, 32'h0);
    chk(rv, 32'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      temp_sample <= 12'($urandom);
      see(1'b1);
      see(1'b0);
      xfer(i == 0 ? 8'h03 : 8'h07, 8'h00);
      chk({16'h0, rv[15:0]}, {16'h0, temp_sample, 4'h0});
    end
    xfer(8'h01, 8'h00);
    chk({24'h0, rv[15:8]}, {24'h0, temp_sample[11:4]});
    for (int r = 0; r < 4; r++) begin
      xfer(8'h12, 8'h02 | 8'(r << 5));
      xfer(8'h15, 8'h00);
      chk({24'h0, rv[15:8]}, 32'h02 | 32'(r << 5));
      see(1'b0);
      see(1'b1);
      t0 = $time;
      see(1'b0);
      see(1'b1);
      chk(32'(($time - t0) / 100), TB_PER[r]);
    end
    xfer(8'h25, 8'h00);
    chk({24'h0, rv[15:8]}, {24'h0, RSVD_BYTE});
    xfer(8'h12, 8'h60);
    r0 = rises;
    xfer(8'h12, 8'h61);
    chk({30'h0, mode}, 32'h0);
    chk(rises - r0, 0);
    repeat (6500) @(posedge sys_clk);
    temp_sample <= 12'($urandom);
    r0 = rises;
    xfer(8'h12, 8'h61);
    repeat (1000) @(posedge sys_clk);
    chk(rises - r0, 1);
    chk({30'h0, mode}, 32'h0);
    xfer(8'h07, 8'h00);
    chk({16'h0, rv[15:0]}, {16'h0, temp_sample, 4'h0});
    finish_test;
  end
endmodule
